// *** dv/ifll_inhibit_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Inhibit wiring: hood switch, or a fault line chained in
module ifll_inhibit_model (
   input  wire logic clk,
   input  wire logic hood_open,
   input  wire logic chain_en,
   input  wire logic fault_chain,
   output var logic  inhibit_in_line = 1'b0
);
   // Registered so the pin moves just after an edge, never on it
   always @(posedge clk) begin
      inhibit_in_line <= hood_open | (chain_en & fault_chain);
   end
endmodule
`default_nettype wire

// *** dv/ifll_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks of the fault latch block
module ifll_properties
   import ifll_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  inhibit_in_line,
   input wire logic [IFLL_WIDTH-1:0] fault_cond_in,
   input wire logic [3:0]            addr,
   input wire logic [15:0]           wdata,
   input wire logic                  wr_stb,
   input wire logic                  rd_stb,
   input wire logic                  fault_out_line,
   input wire logic                  output_enable,
   input wire logic [15:0]           vset_out,
   input wire logic [15:0]           iset_out,
   input wire logic                  irq
);
   logic [7:0] unmask_reg;
   logic [7:0] imask_reg;
   wire        fault_rd = rd_stb && addr == IFLL_FAULT_OFS;
   wire        clr_cmd  = wr_stb && addr == IFLL_CMD_OFS && wdata[7:0] == IFLL_CMD_CLR;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Mask shadows replayed from the bus; clear drops the fault mask only
   always_ff @(posedge clk) begin
      if (rst) begin
         unmask_reg <= IFLL_UNMASK_RST;
         imask_reg  <= IFLL_IMASK_RST;
      end else begin
         if (wr_stb && addr == IFLL_UNMASK_OFS) begin
            unmask_reg <= wdata[7:0];
         end else if (clr_cmd) begin
            unmask_reg <= IFLL_UNMASK_RST;
         end
         if (wr_stb && addr == IFLL_IMASK_OFS) begin
            imask_reg <= wdata[7:0];
         end
      end
   end
   // ==========================================
   // Steps
   sequence s_inh_rise;
      $rose(inhibit_in_line);
   endsequence
   // Inputs still for two cycles, so no late set can race the read
   sequence s_quiet_read;
      fault_rd && $stable(inhibit_in_line) && $past(inhibit_in_line, 2) == inhibit_in_line
         && $stable(fault_cond_in) && $past(fault_cond_in, 2) == fault_cond_in;
   endsequence
   // ==========================================
   // Assertions
   chk_inh_disables: assert property (s_inh_rise |-> ##[1:2] !output_enable)
      else $error("output stayed on after inhibit");
   chk_release_keeps_off: assert property (
      $fell(inhibit_in_line) && !output_enable && !wr_stb && !$past(wr_stb)
      && !$past(wr_stb, 2) |=> !output_enable)
      else $error("output came back on release");
   chk_unmasked_trip: assert property (
      s_inh_rise ##0 unmask_reg[IFLL_BIT_RI] |-> ##[1:2] fault_out_line)
      else $error("fault line missing on unmasked trip");
   chk_masked_quiet: assert property (
      unmask_reg == 8'h00 && $past(unmask_reg) == 8'h00 && !fault_out_line |=> !fault_out_line)
      else $error("fault line rose while all masked");
   chk_read_clears: assert property (s_quiet_read |=> !fault_out_line)
      else $error("fault line held after fault read");
   chk_fault_latched: assert property (
      fault_out_line && !fault_rd && !clr_cmd |=> fault_out_line)
      else $error("fault line dropped without read");
   chk_other_fault: assert property (
      |((fault_cond_in & ~$past(fault_cond_in)) & unmask_reg & 8'hfe)
      |-> ##[1:2] fault_out_line)
      else $error("unmasked fault did not raise line");
   chk_clear_power_on: assert property (clr_cmd |-> ##[1:2] (!output_enable
      && vset_out == IFLL_SET_RST && iset_out == IFLL_SET_RST && !fault_out_line))
      else $error("clear left state behind");
   chk_irq_masked: assert property (imask_reg == 8'h00 |-> !irq)
      else $error("interrupt high while masked");
endmodule
bind ifll_top ifll_properties u_ifll_properties (
   .clk            (clk),
   .rst            (rst),
   .inhibit_in_line(inhibit_in_line),
   .fault_cond_in  (fault_cond_in),
   .addr           (addr),
   .wdata          (wdata),
   .wr_stb         (wr_stb),
   .rd_stb         (rd_stb),
   .fault_out_line (fault_out_line),
   .output_enable  (output_enable),
   .vset_out       (vset_out),
   .iset_out       (iset_out),
   .irq            (irq)
);
`default_nettype wire

// *** dv/inhibit_fault_latch_logic_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the inhibit and fault latch block
module inhibit_fault_latch_logic_test
   import ifll_pkg::*;
;
   logic        clk;
   logic        rst = 1'b1;
   logic        inhibit_in_line;
   logic [7:0]  fault_cond_in = 8'h00;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [15:0] rdata;
   logic        fault_out_line;
   logic        output_enable;
   logic [15:0] vset_out;
   logic [15:0] iset_out;
   logic        srq_out;
   logic        irq;
   logic        hood_open = 1'b0;
   logic        chain_en = 1'b0;
   logic [15:0] rd_val;
   logic [15:0] vset_val;
   logic [31:0] seed = 32'h00000023;
   int          errors = 0;
   int          total_checks = 0;
   ifll_top u_ifll_top (.clk(clk), .rst(rst), .inhibit_in_line(inhibit_in_line),
      .fault_cond_in(fault_cond_in), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .fault_out_line(fault_out_line),
      .output_enable(output_enable), .vset_out(vset_out), .iset_out(iset_out),
      .srq_out(srq_out), .irq(irq));
   ifll_inhibit_model u_ifll_inhibit_model (.clk(clk), .hood_open(hood_open),
      .chain_en(chain_en), .fault_chain(fault_out_line), .inhibit_in_line(inhibit_in_line));
   // ==========================================
   // Helpers
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Latched flags are the events that the mask lets through
   function automatic logic [15:0] exp_flags(input logic [7:0] um, input logic [7:0] ev);
      return {8'h00, um & ev};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the hundred or so cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      end_sim();
   end
   // ==========================================
   // Tests
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(IFLL_UNMASK_OFS, rd_val);
      chk(rd_val, {8'h00, IFLL_UNMASK_RST});
      rd(4'hf, rd_val);
      chk(rd_val, 16'h0000);
      $display("test reset done");
      seed = xs(seed);
      vset_val = seed[15:0];
      wr(IFLL_VSET_OFS, vset_val);
      wr(IFLL_ISET_OFS, seed[31:16]);
      wr(IFLL_UNMASK_OFS, 16'h0001);
      wr(IFLL_IMASK_OFS, 16'h0001);
      wr(IFLL_CTRL_OFS, 16'h0003);
      @(posedge clk);
      hood_open <= 1'b1;
      wait_cyc(5);
      chk(16'({output_enable, fault_out_line, srq_out, irq}), 16'h0007);
      rd(IFLL_STATUS_OFS, rd_val);
      chk(rd_val & 16'h0001, 16'h0001);
      rd(IFLL_ACCUM_OFS, rd_val);
      chk(rd_val & 16'h0001, 16'h0001);
      rd(IFLL_SPOLL_OFS, rd_val);
      chk(rd_val & 16'h0001, 16'h0001);
      rd(IFLL_IRQ_OFS, rd_val);
      chk(16'({rd_val[0], irq}), 16'h0002);
      @(posedge clk);
      hood_open <= 1'b0;
      wait_cyc(5);
      chk(16'({output_enable, fault_out_line}), 16'h0001);
      rd(IFLL_FAULT_OFS, rd_val);
      chk(rd_val, exp_flags(8'h01, 8'h01));
      chk(16'(fault_out_line), 16'h0000);
      wr(IFLL_CMD_OFS, {8'h00, IFLL_CMD_RST});
      wait_cyc(3);
      chk(16'(output_enable), 16'h0001);
      chk(vset_out, vset_val);
      $display("test inhibit trip done");
      // Faults on bits 1 to 3 chained back into the inhibit pin
      chain_en <= 1'b1;
      for (int b = 1; b < 4; b++) begin
         wr(IFLL_UNMASK_OFS, 16'(1 << b));
         @(posedge clk);
         fault_cond_in <= 8'(1 << b);
         wait_cyc(6);
         chk(16'({output_enable, fault_out_line}), 16'h0001);
         rd(IFLL_FAULT_OFS, rd_val);
         chk(rd_val, exp_flags(8'(1 << b), 8'(1 << b)));
         @(posedge clk);
         fault_cond_in <= 8'h00;
         wr(IFLL_CMD_OFS, {8'h00, IFLL_CMD_RST});
         wait_cyc(3);
         chk(16'(output_enable), 16'h0001);
      end
      $display("test chained faults done");
      wr(IFLL_UNMASK_OFS, 16'h0000);
      wr(IFLL_IMASK_OFS, 16'h0000);
      hood_open <= 1'b1;
      wait_cyc(5);
      chk(16'({output_enable, fault_out_line, irq}), 16'h0000);
      @(posedge clk);
      hood_open <= 1'b0;
      rd(IFLL_FAULT_OFS, rd_val);
      chk(rd_val, exp_flags(8'h00, 8'h01));
      wr(IFLL_CMD_OFS, {8'h00, IFLL_CMD_CLR});
      wait_cyc(3);
      chk(16'(output_enable), 16'h0000);
      chk(vset_out | iset_out, IFLL_SET_RST);
      rd(IFLL_CTRL_OFS, rd_val);
      chk(rd_val, 16'(IFLL_CTRL_RST));
      $display("test masked and clear done");
      end_sim();
   end
endmodule
`default_nettype wire

// *** hdl/ifll_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Rising edge detector for an already synchronous level
module ifll_edge
   import ifll_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic level_in,
   output logic      rise_pulse
);
   logic prev_reg;

   // Previous level
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= level_in;
      end
   end

   // One cycle pulse on a low to high change
   assign rise_pulse = level_in & ~prev_reg;
endmodule
`default_nettype wire

// *** hdl/ifll_pkg.sv ***
// Summary of operation
// - Inhibit input turns the output off, but leaves the output bit of the control register unchanged.
// - Inhibit shows at once in the remote-inhibit bit of status and is latched into accumulated status one clock later.
// - Fault output line goes true on inhibit only when unmask bit is set.
// - Unmasked inhibit sets fault register flag and serial poll fault summary.
// - Releasing inhibit never re-enables output; software must recover explicitly.
// - Reading the fault register clears fault output line and inhibit flag.
// - Clear command returns output state and settings to power-on values.
// - Fault output line asserts for any unmasked fault, not only inhibit.
// - Fault query then restore command brings back outputs programmed before trip.
// - A fault that disables the supply can raise a service request.
package ifll_pkg;
   // ==========================================
   // Register offsets
   localparam logic [3:0] IFLL_STATUS_OFS  = 4'h0;
   localparam logic [3:0] IFLL_ACCUM_OFS   = 4'h1;
   localparam logic [3:0] IFLL_UNMASK_OFS  = 4'h2;
   localparam logic [3:0] IFLL_FAULT_OFS   = 4'h3;
   localparam logic [3:0] IFLL_SPOLL_OFS   = 4'h4;
   localparam logic [3:0] IFLL_CTRL_OFS    = 4'h5;
   localparam logic [3:0] IFLL_VSET_OFS    = 4'h6;
   localparam logic [3:0] IFLL_ISET_OFS    = 4'h7;
   localparam logic [3:0] IFLL_CMD_OFS     = 4'h8;
   localparam logic [3:0] IFLL_IRQ_OFS     = 4'h9;
   localparam logic [3:0] IFLL_IMASK_OFS   = 4'ha;
   // ==========================================
   // Fault/status bit positions (8 bits)
   localparam int IFLL_WIDTH      = 8;
   localparam int IFLL_BIT_RI     = 0;
   localparam int IFLL_BIT_OV     = 1;
   localparam int IFLL_BIT_OT     = 2;
   localparam int IFLL_BIT_ERR    = 3;
   // Serial poll bits
   localparam int IFLL_SP_FAU     = 0;
   localparam int IFLL_SP_RQS     = 6;
   // Control register bits
   localparam int IFLL_CTRL_OUT   = 0;
   localparam int IFLL_CTRL_SRQEN = 1;
   // Command codes written to the command register
   localparam logic [7:0] IFLL_CMD_CLR = 8'h01;
   localparam logic [7:0] IFLL_CMD_RST = 8'h02;
   // Interrupt event bits
   localparam int IFLL_EV_INH     = 0;
   localparam int IFLL_EV_FAULT   = 1;
   // ==========================================
   // Reset values
   localparam logic [7:0]  IFLL_UNMASK_RST = 8'h00;
   localparam logic [7:0]  IFLL_CTRL_RST   = 8'h00;
   localparam logic [15:0] IFLL_SET_RST    = 16'h0000;
   localparam logic [7:0]  IFLL_IMASK_RST  = 8'h00;
endpackage

// *** hdl/ifll_sticky.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sticky flag bank: set wins over clear
module ifll_sticky
   import ifll_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [IFLL_WIDTH-1:0] set_in,
   input  wire logic                  clear_in,
   output logic      [IFLL_WIDTH-1:0] flags_reg
);
   // Event in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= '0;
      end else if (clear_in) begin
         flags_reg <= set_in;
      end else begin
         flags_reg <= flags_reg | set_in;
      end
   end
endmodule
`default_nettype wire

// *** hdl/ifll_top.sv ***
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Inhibit and fault latch logic for the supply
module ifll_top
   import ifll_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  inhibit_in_line,
   input  wire logic [IFLL_WIDTH-1:0] fault_cond_in,
   input  wire logic [3:0]            addr,
   input  wire logic [15:0]           wdata,
   input  wire logic                  wr_stb,
   input  wire logic                  rd_stb,
   output logic      [15:0]           rdata,
   output logic                       fault_out_line,
   output logic                       output_enable,
   output logic      [15:0]           vset_out,
   output logic      [15:0]           iset_out,
   output logic                       srq_out,
   output logic                       irq
);
   // ==========================================
   // Declarations
   logic                  inh_rise;
   logic [IFLL_WIDTH-1:0] cond_rise;
   logic [IFLL_WIDTH-1:0] status_now;
   logic [IFLL_WIDTH-1:0] event_vec;
   logic [IFLL_WIDTH-1:0] accum_reg;
   logic [IFLL_WIDTH-1:0] fault_reg;
   logic [IFLL_WIDTH-1:0] fault_set;
   logic [IFLL_WIDTH-1:0] unmask_reg;
   logic [IFLL_WIDTH-1:0] irq_stat_reg;
   logic [IFLL_WIDTH-1:0] irq_set;
   logic [IFLL_WIDTH-1:0] imask_reg;
   logic [7:0]            ctrl_reg;
   logic [15:0]           vset_reg;
   logic [15:0]           iset_reg;
   logic                  out_on_reg;
   logic                  tripped_reg;
   logic                  fault_queried_reg;
   logic                  rqs_reg;
   logic                  fault_rd;
   logic                  accum_rd;
   logic                  irq_rd;
   logic                  cmd_clr;
   logic                  cmd_rst;
   logic                  out_cmd_wr;
   logic                  disable_evt;
   logic [15:0]           rdata_next;

   // Access decode shared by several processes
   function automatic logic hit(input logic stb, input logic [3:0] a, input logic [3:0] ofs);
      hit = stb && (a == ofs);
   endfunction

   assign fault_rd   = hit(rd_stb, addr, IFLL_FAULT_OFS);
   assign accum_rd   = hit(rd_stb, addr, IFLL_ACCUM_OFS);
   assign irq_rd     = hit(rd_stb, addr, IFLL_IRQ_OFS);
   assign cmd_clr    = hit(wr_stb, addr, IFLL_CMD_OFS) && (wdata[7:0] == IFLL_CMD_CLR);
   assign cmd_rst    = hit(wr_stb, addr, IFLL_CMD_OFS) && (wdata[7:0] == IFLL_CMD_RST);
   assign out_cmd_wr = hit(wr_stb, addr, IFLL_CTRL_OFS);

   // ==========================================
   // Event detection
   ifll_edge u_inh_edge (
      .clk        (clk),
      .rst        (rst),
      .level_in   (inhibit_in_line),
      .rise_pulse (inh_rise)
   );

   genvar gi;
   generate
      for (gi = 0; gi < IFLL_WIDTH; gi++) begin : g_cond
         if (gi == IFLL_BIT_RI) begin : g_ri
            assign cond_rise[gi] = inh_rise;
         end else begin : g_other
            ifll_edge u_edge (
               .clk        (clk),
               .rst        (rst),
               .level_in   (fault_cond_in[gi]),
               .rise_pulse (cond_rise[gi])
            );
         end
      end
   endgenerate

   always_comb begin
      status_now              = fault_cond_in;
      status_now[IFLL_BIT_RI] = inhibit_in_line;
   end

   assign event_vec = cond_rise;

   // ==========================================
   // Accumulated status: clears on read, set wins
   // accumulated flag
   ifll_sticky u_accum (
      .clk       (clk),
      .rst       (rst | cmd_clr),
      .set_in    (event_vec),
      .clear_in  (accum_rd),
      .flags_reg (accum_reg)
   );

   assign fault_set = event_vec & unmask_reg;

   ifll_sticky u_fault (
      .clk       (clk),
      .rst       (rst | cmd_clr),
      .set_in    (fault_set),
      .clear_in  (fault_rd),
      .flags_reg (fault_reg)
   );

   assign fault_out_line = |fault_reg;

   // ==========================================
   // Unmask and control registers
   always_ff @(posedge clk) begin
      if (rst || cmd_clr) begin
         unmask_reg <= IFLL_UNMASK_RST;
      end else if (hit(wr_stb, addr, IFLL_UNMASK_OFS)) begin
         unmask_reg <= wdata[IFLL_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst || cmd_clr) begin
         ctrl_reg <= IFLL_CTRL_RST;
         vset_reg <= IFLL_SET_RST;
         iset_reg <= IFLL_SET_RST;
      end else begin
         if (out_cmd_wr) begin
            ctrl_reg <= wdata[7:0];
         end
         if (hit(wr_stb, addr, IFLL_VSET_OFS)) begin
            vset_reg <= wdata;
         end
         if (hit(wr_stb, addr, IFLL_ISET_OFS)) begin
            iset_reg <= wdata;
         end
      end
   end

   // ==========================================
   // Output enable and trip handling
   assign disable_evt = inh_rise | (|fault_set);

   // Fault register read arms the restore command
   always_ff @(posedge clk) begin
      if (rst || cmd_clr || disable_evt) begin
         fault_queried_reg <= 1'b0;
      end else if (fault_rd && tripped_reg) begin
         fault_queried_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || cmd_clr) begin
         tripped_reg <= 1'b0;
      end else if (inh_rise) begin
         tripped_reg <= 1'b1;
      end else if (cmd_rst && fault_queried_reg) begin
         tripped_reg <= 1'b0;
      end
   end

   // restore prior program
   // Settings are never overwritten by a trip, so restore only re-opens the gate
   always_ff @(posedge clk) begin
      if (rst || cmd_clr) begin
         out_on_reg <= 1'b0;
      end else if (inh_rise) begin
         out_on_reg <= 1'b0;
      end else begin
         out_on_reg <= ctrl_reg[IFLL_CTRL_OUT] & ~tripped_reg;
      end
   end

   // Data outputs from flops; the trip gates output_enable only, so settings survive
   always_ff @(posedge clk) begin
      if (rst) begin
         vset_out <= IFLL_SET_RST;
         iset_out <= IFLL_SET_RST;
      end else begin
         vset_out <= vset_reg;
         iset_out <= iset_reg;
      end
   end

   assign output_enable = out_on_reg;

   // ==========================================
   // Service request
   // fault raises request
   always_ff @(posedge clk) begin
      if (rst || cmd_clr) begin
         rqs_reg <= 1'b0;
      end else if (|fault_set && ctrl_reg[IFLL_CTRL_SRQEN]) begin
         rqs_reg <= 1'b1;
      end else if (hit(rd_stb, addr, IFLL_SPOLL_OFS)) begin
         rqs_reg <= 1'b0;
      end
   end

   assign srq_out = rqs_reg;

   // ==========================================
   // Interrupt status: read clears, set wins
   always_comb begin
      irq_set                = '0;
      irq_set[IFLL_EV_INH]   = inh_rise;
      irq_set[IFLL_EV_FAULT] = |fault_set;
   end

   ifll_sticky u_irq (
      .clk       (clk),
      .rst       (rst),
      .set_in    (irq_set),
      .clear_in  (irq_rd),
      .flags_reg (irq_stat_reg)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         imask_reg <= IFLL_IMASK_RST;
      end else if (hit(wr_stb, addr, IFLL_IMASK_OFS)) begin
         imask_reg <= wdata[IFLL_WIDTH-1:0];
      end
   end

   assign irq = |(irq_stat_reg & imask_reg);

   // ==========================================
   // Read mux, answer one cycle after the strobe
   always_comb begin
      rdata_next = 16'h0000;
      case (addr)
         IFLL_STATUS_OFS: rdata_next[IFLL_WIDTH-1:0] = status_now;
         IFLL_ACCUM_OFS:  rdata_next[IFLL_WIDTH-1:0] = accum_reg;
         IFLL_UNMASK_OFS: rdata_next[IFLL_WIDTH-1:0] = unmask_reg;
         IFLL_FAULT_OFS:  rdata_next[IFLL_WIDTH-1:0] = fault_reg;
         IFLL_SPOLL_OFS: begin
            // Fault summary follows the fault register
            rdata_next[IFLL_SP_FAU] = |fault_reg;
            rdata_next[IFLL_SP_RQS] = rqs_reg;
         end
         IFLL_CTRL_OFS: begin
            rdata_next[7:0]         = ctrl_reg;
            rdata_next[8]           = out_on_reg;
            rdata_next[9]           = tripped_reg;
         end
         IFLL_VSET_OFS:   rdata_next = vset_reg;
         IFLL_ISET_OFS:   rdata_next = iset_reg;
         IFLL_IRQ_OFS:    rdata_next[IFLL_WIDTH-1:0] = irq_stat_reg;
         IFLL_IMASK_OFS:  rdata_next[IFLL_WIDTH-1:0] = imask_reg;
         default:         rdata_next = 16'h0000;
      endcase
   end

   // Data valid only in the cycle after a read strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (rd_stb) begin
         rdata <= rdata_next;
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule
`default_nettype wire
